/* logic/fpec_pkg.sv */
// package: constants and types of the flash program/erase controller
`default_nettype none
package fpec_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_OP_CONTROL = 8'h00;
  localparam logic [7:0] OFS_UNLOCK_KEY = 8'h04;
  localparam logic [7:0] OFS_TABLE_PAGE = 8'h08;
  localparam logic [7:0] OFS_TABLE_PTR = 8'h0C;
  localparam logic [7:0] OFS_TABLE_WR_LOW = 8'h10;
  localparam logic [7:0] OFS_TABLE_WR_HIGH = 8'h14;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h1C;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h20;
  // op control fields
  localparam int BIT_START = 15;
  localparam int BIT_ENABLE = 14;
  localparam int BIT_SEQ_ERR = 13;
  localparam int BIT_ERASE = 6;
  localparam int OPC_LSB = 0;
  localparam int OPC_W = 4;
  localparam logic [15:0] OP_CONTROL_RST = 16'h0000;
  // unlock key values
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  // irq status bit positions
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_W = 2;
  // timing
  localparam int CLK_MHZ = 200;
  localparam int ROW_TIME_NS = 1435000;
  localparam int ROW_CYCLES = (ROW_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int ERASE_CYCLES = 400000;
  localparam int SHORT_CYCLES = 100000;
  localparam int CNT_W = 20;
  localparam int LATCH_DEPTH = 64;
  localparam int WORD_W = 24;

  typedef enum logic [3:0] {
    FPEC_K_BAD, FPEC_K_NOP, FPEC_K_BULK, FPEC_K_SEG, FPEC_K_SEG2, FPEC_K_PAGE,
    FPEC_K_CFG_ERASE, FPEC_K_ROW, FPEC_K_REST, FPEC_K_CFG_PROG
  } fpec_kind_e;

  typedef enum logic [1:0] {
    FPEC_IDLE = 2'b00,
    FPEC_RUN = 2'b01,
    FPEC_DONE = 2'b11
  } fpec_state_e;

  typedef enum logic [1:0] {
    FPEC_KEY_NONE = 2'b00,
    FPEC_KEY_HALF = 2'b01,
    FPEC_KEY_ARMED = 2'b11
  } fpec_key_e;

  typedef struct packed {
    logic start;
    fpec_kind_e kind;
    logic [WORD_W-1:0] addr;
  } fpec_cmd_s;
endpackage : fpec_pkg
`default_nettype wire

/* logic/fpec_top.sv */
// module: flash program/erase sequencer with ahb-lite register slave
//
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module fpec_top #(
  parameter int ROW_CYCLES = fpec_pkg::ROW_CYCLES,
  parameter int ERASE_CYCLES = fpec_pkg::ERASE_CYCLES,
  parameter int SHORT_CYCLES = fpec_pkg::SHORT_CYCLES
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  input wire logic [5:0] arr_lat_idx_i,
  output logic [fpec_pkg::WORD_W-1:0] arr_lat_data_o,
  output fpec_pkg::fpec_cmd_s arr_cmd_o,
  output logic arr_busy_o,
  output logic cpu_stall_o,
  output logic irq_o
);
  // operation class from erase select and code
  function automatic fpec_pkg::fpec_kind_e op_kind(input logic erase, input logic [3:0] opc);
    fpec_pkg::fpec_kind_e k;
    k = fpec_pkg::FPEC_K_BAD;
    if (erase) begin
      case (opc)
        4'hF: k = fpec_pkg::FPEC_K_BULK;
        4'hD: k = fpec_pkg::FPEC_K_SEG;
        4'hC: k = fpec_pkg::FPEC_K_SEG2;
        4'h2: k = fpec_pkg::FPEC_K_PAGE;
        4'h0: k = fpec_pkg::FPEC_K_CFG_ERASE;
        4'h3, 4'h1: k = fpec_pkg::FPEC_K_NOP;
        default: k = fpec_pkg::FPEC_K_BAD;
      endcase
    end else begin
      case (opc)
        4'h1: k = fpec_pkg::FPEC_K_ROW;
        4'h3: k = fpec_pkg::FPEC_K_REST;
        4'h0: k = fpec_pkg::FPEC_K_CFG_PROG;
        4'hF, 4'hD, 4'hC, 4'h2: k = fpec_pkg::FPEC_K_NOP;
        default: k = fpec_pkg::FPEC_K_BAD;
      endcase
    end
    return k;
  endfunction : op_kind

  // duration of a class in clock cycles
  function automatic logic [fpec_pkg::CNT_W-1:0] op_cycles(input fpec_pkg::fpec_kind_e k);
    logic [fpec_pkg::CNT_W-1:0] c;
    case (k)
      fpec_pkg::FPEC_K_NOP: c = 20'h00001;
      fpec_pkg::FPEC_K_ROW, fpec_pkg::FPEC_K_REST: c = fpec_pkg::CNT_W'(ROW_CYCLES);
      fpec_pkg::FPEC_K_CFG_ERASE, fpec_pkg::FPEC_K_CFG_PROG: c = fpec_pkg::CNT_W'(SHORT_CYCLES);
      default: c = fpec_pkg::CNT_W'(ERASE_CYCLES);
    endcase
    return c;
  endfunction : op_cycles

  // ahb address phase capture
  logic wr_pend_ff;
  logic nxt_wr_pend;
  logic [7:0] wr_ofs_ff;
  logic [7:0] nxt_wr_ofs;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  // registers
  logic start_ff;
  logic nxt_start;
  logic enable_ff;
  logic nxt_enable;
  logic seq_err_ff;
  logic nxt_seq_err;
  logic erase_ff;
  logic nxt_erase;
  logic [3:0] opc_ff;
  logic [3:0] nxt_opc;
  fpec_pkg::fpec_key_e key_ff;
  fpec_pkg::fpec_key_e nxt_key;
  logic [7:0] page_ff;
  logic [7:0] nxt_page;
  logic [15:0] ptr_ff;
  logic [15:0] nxt_ptr;
  logic [fpec_pkg::IRQ_W-1:0] irq_st_ff;
  logic [fpec_pkg::IRQ_W-1:0] nxt_irq_st;
  logic [fpec_pkg::IRQ_W-1:0] irq_en_ff;
  logic [fpec_pkg::IRQ_W-1:0] nxt_irq_en;
  logic irq_ff;
  logic nxt_irq;
  // sequencer
  fpec_pkg::fpec_state_e state_ff;
  fpec_pkg::fpec_state_e nxt_state;
  logic [fpec_pkg::CNT_W-1:0] cnt_ff;
  logic [fpec_pkg::CNT_W-1:0] nxt_cnt;
  fpec_pkg::fpec_cmd_s cmd_ff;
  fpec_pkg::fpec_cmd_s nxt_cmd;
  logic busy_ff;
  logic nxt_busy;
  // holding latches
  logic [fpec_pkg::WORD_W-1:0] latch_mem [fpec_pkg::LATCH_DEPTH];
  logic [fpec_pkg::WORD_W-1:0] lat_rd_ff;
  logic [fpec_pkg::WORD_W-1:0] nxt_lat_rd;
  logic [fpec_pkg::WORD_W-1:0] nxt_lat_word;

  logic addr_ok;
  logic wr_now;
  logic [15:0] op_ctl_rd;
  logic [5:0] lat_idx;
  logic lat_wr_lo;
  logic lat_wr_hi;
  fpec_pkg::fpec_kind_e req_kind;
  logic start_req;
  logic finish;
  logic launch;

  assign addr_ok = hsel_i && hready_i && htrans_i[1];
  assign wr_now = wr_pend_ff;
  assign op_ctl_rd = {nxt_start, nxt_enable, nxt_seq_err, 6'h00,
                      nxt_erase, 2'h0, nxt_opc};
  assign lat_idx = ptr_ff[6:1];
  assign lat_wr_lo = wr_now && (wr_ofs_ff == fpec_pkg::OFS_TABLE_WR_LOW);
  assign lat_wr_hi = wr_now && (wr_ofs_ff == fpec_pkg::OFS_TABLE_WR_HIGH);
  assign req_kind = op_kind(hwdata_i[fpec_pkg::BIT_ERASE],
                            hwdata_i[fpec_pkg::OPC_LSB +: fpec_pkg::OPC_W]);
  assign start_req = wr_now && (wr_ofs_ff == fpec_pkg::OFS_OP_CONTROL)
                     && hwdata_i[fpec_pkg::BIT_START] && !start_ff;
  assign finish = (state_ff == fpec_pkg::FPEC_RUN) && (cnt_ff == 20'h00001);
  assign launch = start_req && nxt_start;

  // bus slave: capture address, read data ready for data phase
  // read data from next values so a write landing this cycle is seen
  always_comb begin
    nxt_wr_pend = addr_ok && hwrite_i;
    nxt_wr_ofs = addr_ok ? haddr_i[7:0] : wr_ofs_ff;
    nxt_rdata = rdata_ff;
    if (addr_ok && !hwrite_i) begin
      case (haddr_i[7:0])
        fpec_pkg::OFS_OP_CONTROL: nxt_rdata = {16'h0000, op_ctl_rd};
        fpec_pkg::OFS_UNLOCK_KEY: nxt_rdata = 32'h00000000;
        fpec_pkg::OFS_TABLE_PAGE: nxt_rdata = {24'h000000, nxt_page};
        fpec_pkg::OFS_TABLE_PTR: nxt_rdata = {16'h0000, nxt_ptr};
        fpec_pkg::OFS_IRQ_STATUS: nxt_rdata = {30'h00000000, nxt_irq_st};
        fpec_pkg::OFS_IRQ_ENABLE: nxt_rdata = {30'h00000000, nxt_irq_en};
        default: nxt_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wr_pend_ff <= 1'b0;
      wr_ofs_ff <= 8'h00;
      rdata_ff <= 32'h00000000;
    end else begin
      wr_pend_ff <= nxt_wr_pend;
      wr_ofs_ff <= nxt_wr_ofs;
      rdata_ff <= nxt_rdata;
    end
  end

  // register file, unlock tracking and interrupt flags
  always_comb begin
    nxt_start = start_ff;
    nxt_enable = enable_ff;
    nxt_seq_err = seq_err_ff;
    nxt_erase = erase_ff;
    nxt_opc = opc_ff;
    nxt_key = key_ff;
    nxt_page = page_ff;
    nxt_ptr = ptr_ff;
    nxt_irq_st = irq_st_ff;
    nxt_irq_en = irq_en_ff;
    if (wr_now) begin
      nxt_key = fpec_pkg::FPEC_KEY_NONE;
      case (wr_ofs_ff)
        fpec_pkg::OFS_UNLOCK_KEY: begin
          if (hwdata_i[7:0] == fpec_pkg::KEY_FIRST) begin
            nxt_key = fpec_pkg::FPEC_KEY_HALF;
          end else if (hwdata_i[7:0] == fpec_pkg::KEY_SECOND
                       && key_ff == fpec_pkg::FPEC_KEY_HALF) begin
            nxt_key = fpec_pkg::FPEC_KEY_ARMED;
          end
        end
        fpec_pkg::OFS_OP_CONTROL: begin
          if (!start_ff) begin
            nxt_enable = hwdata_i[fpec_pkg::BIT_ENABLE];
            nxt_seq_err = hwdata_i[fpec_pkg::BIT_SEQ_ERR];
            nxt_erase = hwdata_i[fpec_pkg::BIT_ERASE];
            nxt_opc = hwdata_i[fpec_pkg::OPC_LSB +: fpec_pkg::OPC_W];
          end
        end
        fpec_pkg::OFS_TABLE_PAGE: nxt_page = hwdata_i[7:0];
        fpec_pkg::OFS_TABLE_PTR: nxt_ptr = hwdata_i[15:0];
        fpec_pkg::OFS_TABLE_WR_HIGH: nxt_ptr = ptr_ff + 16'h0002;
        fpec_pkg::OFS_IRQ_CLEAR: nxt_irq_st = irq_st_ff & ~hwdata_i[fpec_pkg::IRQ_W-1:0];
        fpec_pkg::OFS_IRQ_ENABLE: nxt_irq_en = hwdata_i[fpec_pkg::IRQ_W-1:0];
        default: nxt_key = fpec_pkg::FPEC_KEY_NONE;
      endcase
    end
    if (start_req) begin
      if (key_ff == fpec_pkg::FPEC_KEY_ARMED && hwdata_i[fpec_pkg::BIT_ENABLE]
          && req_kind != fpec_pkg::FPEC_K_BAD) begin
        nxt_start = 1'b1;
      end else begin
        nxt_seq_err = 1'b1;
        nxt_irq_st[fpec_pkg::IRQ_ERR] = 1'b1;
      end
    end
    if (finish) begin
      nxt_start = 1'b0;
      nxt_seq_err = 1'b0;
      nxt_irq_st[fpec_pkg::IRQ_DONE] = 1'b1;
    end
    nxt_irq = |(nxt_irq_st & nxt_irq_en);
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      start_ff <= fpec_pkg::OP_CONTROL_RST[fpec_pkg::BIT_START];
      enable_ff <= fpec_pkg::OP_CONTROL_RST[fpec_pkg::BIT_ENABLE];
      seq_err_ff <= fpec_pkg::OP_CONTROL_RST[fpec_pkg::BIT_SEQ_ERR];
      erase_ff <= fpec_pkg::OP_CONTROL_RST[fpec_pkg::BIT_ERASE];
      opc_ff <= fpec_pkg::OP_CONTROL_RST[fpec_pkg::OPC_LSB +: fpec_pkg::OPC_W];
      key_ff <= fpec_pkg::FPEC_KEY_NONE;
      page_ff <= 8'h00;
      ptr_ff <= 16'h0000;
      irq_st_ff <= 2'h0;
      irq_en_ff <= 2'h0;
      irq_ff <= 1'b0;
    end else begin
      start_ff <= nxt_start;
      enable_ff <= nxt_enable;
      seq_err_ff <= nxt_seq_err;
      erase_ff <= nxt_erase;
      opc_ff <= nxt_opc;
      key_ff <= nxt_key;
      page_ff <= nxt_page;
      ptr_ff <= nxt_ptr;
      irq_st_ff <= nxt_irq_st;
      irq_en_ff <= nxt_irq_en;
      irq_ff <= nxt_irq;
    end
  end

  // self-timed sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_cmd = cmd_ff;
    nxt_cmd.start = 1'b0;
    case (state_ff)
      fpec_pkg::FPEC_IDLE, fpec_pkg::FPEC_DONE: begin
        nxt_state = fpec_pkg::FPEC_IDLE;
        if (launch) begin
          nxt_state = fpec_pkg::FPEC_RUN;
          nxt_cnt = op_cycles(req_kind);
          nxt_cmd.start = (req_kind != fpec_pkg::FPEC_K_NOP);
          nxt_cmd.kind = req_kind;
          nxt_cmd.addr = {page_ff, ptr_ff};
        end
      end
      fpec_pkg::FPEC_RUN: begin
        nxt_cnt = cnt_ff - 20'h00001;
        if (finish) begin
          nxt_state = fpec_pkg::FPEC_DONE;
        end
      end
      default: nxt_state = fpec_pkg::FPEC_IDLE;
    endcase
    nxt_busy = (nxt_state == fpec_pkg::FPEC_RUN);
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_ff <= fpec_pkg::FPEC_IDLE;
      cnt_ff <= 20'h00000;
      cmd_ff <= '0;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      cmd_ff <= nxt_cmd;
      busy_ff <= nxt_busy;
    end
  end

  // holding latches: table writes fill, array reads during row program
  always_comb begin
    nxt_lat_word = latch_mem[lat_idx];
    if (lat_wr_lo) begin
      nxt_lat_word[15:0] = hwdata_i[15:0];
    end
    if (lat_wr_hi) begin
      nxt_lat_word[23:16] = hwdata_i[7:0];
    end
    nxt_lat_rd = latch_mem[arr_lat_idx_i];
  end

  always_ff @(posedge mclk_i) begin
    if (lat_wr_lo || lat_wr_hi) begin
      latch_mem[lat_idx] <= nxt_lat_word;
    end
    lat_rd_ff <= nxt_lat_rd;
  end

  // outputs
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = rdata_ff;
  assign arr_lat_data_o = lat_rd_ff;
  assign arr_cmd_o = cmd_ff;
  assign arr_busy_o = busy_ff;
  assign cpu_stall_o = busy_ff;
  assign irq_o = irq_ff;
endmodule : fpec_top
`default_nettype wire

/* dv/fpec_properties.sv */
// checker: port-level properties of the flash sequencer
`timescale 1ns/1ps
`default_nettype none
module fpec_properties #(
  parameter int ROW_CYCLES = 8
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire fpec_pkg::fpec_cmd_s arr_cmd_o,
  input wire logic arr_busy_o,
  input wire logic cpu_stall_o
);
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic rd_a;
  assign rd_a = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
  // busy cycle counter
  always_comb begin
    nxt_cnt = arr_busy_o ? cnt_ff + 32'h1 : 32'h0;
  end
  always_ff @(posedge mclk_i) begin
    cnt_ff <= rst_i ? 32'h0 : nxt_cnt;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  property p_stall; cpu_stall_o == arr_busy_o; endproperty
  a_stall: assert property (p_stall) else $error("stall differs from busy");
  property p_key_rd; rd_a && haddr_i[7:0] == fpec_pkg::OFS_UNLOCK_KEY |=> hrdata_o == 32'h0;
  endproperty
  a_key_rd: assert property (p_key_rd) else $error("key register read nonzero");
  property p_ctl_rd; rd_a && haddr_i[7:0] == fpec_pkg::OFS_OP_CONTROL
    |=> hrdata_o[12:7] == 6'h0 && hrdata_o[5:4] == 2'h0; endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("unused control bits set");
  property p_pulse; arr_cmd_o.start |-> arr_busy_o ##1 !arr_cmd_o.start; endproperty
  a_pulse: assert property (p_pulse) else $error("start pulse wrong");
  property p_rise; $rose(arr_busy_o) |-> $past(hwdata_i[15]); endproperty
  a_rise: assert property (p_rise) else $error("busy without start write");
  property p_enable; arr_cmd_o.start |-> $past(hwdata_i[15:14]) == 2'b11; endproperty
  a_enable: assert property (p_enable) else $error("operation while disabled");
  property p_page; arr_cmd_o.start && arr_cmd_o.kind == fpec_pkg::FPEC_K_PAGE
    |-> $past(hwdata_i[6]) && $past(hwdata_i[3:0]) == 4'h2; endproperty
  a_page: assert property (p_page) else $error("page erase wrong code");
  property p_row; arr_cmd_o.start && arr_cmd_o.kind == fpec_pkg::FPEC_K_ROW
    |-> !$past(hwdata_i[6]) && $past(hwdata_i[3:0]) == 4'h1; endproperty
  a_row: assert property (p_row) else $error("row program wrong code");
  property p_len; $fell(arr_busy_o) && arr_cmd_o.kind == fpec_pkg::FPEC_K_ROW
    |-> cnt_ff == 32'(ROW_CYCLES); endproperty
  a_len: assert property (p_len) else $error("row busy length wrong");
endmodule : fpec_properties
bind fpec_top fpec_properties #(.ROW_CYCLES(ROW_CYCLES)) i_props (.mclk_i, .rst_i, .hsel_i,
  .haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hready_i, .hrdata_o, .arr_cmd_o, .arr_busy_o,
  .cpu_stall_o);
`default_nettype wire

/* dv/fpec_array_model.sv */
// model: flash array reading the holding latches on row program
`timescale 1ns/1ps
`default_nettype none
module fpec_array_model (
  input wire logic clk_i,
  input wire fpec_pkg::fpec_cmd_s cmd_i,
  input wire logic busy_i,
  input wire logic [fpec_pkg::WORD_W-1:0] lat_data_i,
  output logic [5:0] idx_o
);
  logic [fpec_pkg::WORD_W-1:0] flash [64];
  logic [5:0] idx_ff = 6'h00;
  logic [5:0] prev_ff = 6'h00;
  logic rd_ff = 1'b0;
  assign idx_o = idx_ff;
  always_ff @(posedge clk_i) begin
    idx_ff <= busy_i === 1'b1 ? idx_ff + 6'h01 : 6'h00;
    prev_ff <= idx_ff;
    rd_ff <= busy_i === 1'b1 && cmd_i.kind == fpec_pkg::FPEC_K_ROW;
    if (rd_ff) begin
      flash[prev_ff] <= lat_data_i;
    end
  end
endmodule : fpec_array_model
`default_nettype wire

/* dv/test_flash_program_erase_control.sv */
// bench: self-checking test of the flash program/erase sequencer
`timescale 1ns/1ps
`default_nettype none
module test_flash_program_erase_control;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] hrdata, rd, r, seed = 32'd86350;
  logic hreadyout, hresp, busy, stall, irq, ok, st;
  logic [5:0] idx;
  logic [23:0] lat, exp_w [8];
  logic [15:0] c, w;
  fpec_pkg::fpec_cmd_s cmd;
  int mismatches = 0, n_compared = 0, cycles = 0, m;
  fpec_top #(.ROW_CYCLES(8), .ERASE_CYCLES(8), .SHORT_CYCLES(8)) i_dut (.mclk_i(mclk_i),
    .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout), .hreadyout_o(hreadyout),
    .hresp_o(hresp), .hrdata_o(hrdata), .arr_lat_idx_i(idx), .arr_lat_data_o(lat),
    .arr_cmd_o(cmd), .arr_busy_o(busy), .cpu_stall_o(stall), .irq_o(irq));
  fpec_array_model i_arr (.clk_i(mclk_i), .cmd_i(cmd), .busy_i(busy), .lat_data_i(lat),
    .idx_o(idx));
  initial forever #2.5 mclk_i = ~mclk_i;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge mclk_i);
    while (hreadyout !== 1'b1) @(posedge mclk_i);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge mclk_i);
    while (hreadyout !== 1'b1) @(posedge mclk_i);
    rd = hrdata;
  endtask : bus
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(what, e, rd);
  endtask : rdchk
  // mode 0 proper unlock, 1 split by another write, 2 wrong first key
  task automatic op(input logic [15:0] v, input int mode);
    bus(1'b1, fpec_pkg::OFS_OP_CONTROL, {16'h0, v});
    bus(1'b1, fpec_pkg::OFS_UNLOCK_KEY, mode == 2 ? 32'h5A : 32'h55);
    if (mode == 1) bus(1'b1, fpec_pkg::OFS_TABLE_PAGE, 32'h0);
    bus(1'b1, fpec_pkg::OFS_UNLOCK_KEY, 32'hAA);
    bus(1'b1, fpec_pkg::OFS_OP_CONTROL, {16'h0, v | 16'h8000});
    st = 1'b0;
    repeat (2) @(posedge mclk_i);
    while (busy !== 1'b0) begin
      st = st | stall;
      @(posedge mclk_i);
    end
  endtask : op
  initial begin
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    rdchk("control reset", fpec_pkg::OFS_OP_CONTROL, 32'h0);
    bus(1'b1, fpec_pkg::OFS_UNLOCK_KEY, 32'h1234);
    rdchk("key readback", fpec_pkg::OFS_UNLOCK_KEY, 32'h0);
    bus(1'b1, 8'h40, 32'hFFFF);
    rdchk("unmapped", 8'h40, 32'h0);
    bus(1'b1, fpec_pkg::OFS_IRQ_ENABLE, 32'h3);
    $display("test reset values done");
    for (int i = 0; i < 48; i++) begin
      r = rnd();
      m = int'(r[1:0]) % 3;
      c = {1'b0, r[2] | (i < 32), 7'h0, i[4], 2'b0, i[3:0]};
      w = c | (r[31:16] & 16'h1FB0);
      ok = (c[3:0] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'hC, 4'hD, 4'hF}) && c[14] && m == 0;
      op(w, m);
      rdchk("control", fpec_pkg::OFS_OP_CONTROL, {16'h0, ok ? c : c | 16'h2000});
      rdchk("status", fpec_pkg::OFS_IRQ_STATUS, ok ? 32'h1 : 32'h2);
      chk("irq", 32'h1, {31'h0, irq});
      bus(1'b1, fpec_pkg::OFS_IRQ_CLEAR, 32'h3);
      rdchk("status cleared", fpec_pkg::OFS_IRQ_STATUS, 32'h0);
      chk("irq cleared", 32'h0, {31'h0, irq});
    end
    $display("test operation codes done");
    r = rnd();
    bus(1'b1, fpec_pkg::OFS_TABLE_PAGE, {24'h0, r[7:0]});
    bus(1'b1, fpec_pkg::OFS_TABLE_PTR, {16'h0, r[23:9], 1'b0});
    op(16'h4042, 0);
    chk("page address", {8'h0, r[7:0], r[23:9], 1'b0}, {8'h0, cmd.addr});
    chk("page kind", {28'h0, fpec_pkg::FPEC_K_PAGE}, {28'h0, cmd.kind});
    $display("test page erase done");
    bus(1'b1, fpec_pkg::OFS_TABLE_PAGE, 32'h0);
    bus(1'b1, fpec_pkg::OFS_TABLE_PTR, 32'h0);
    for (int k = 0; k < 8; k++) begin
      exp_w[k] = 24'(rnd());
      bus(1'b1, fpec_pkg::OFS_TABLE_WR_LOW, {16'h0, exp_w[k][15:0]});
      bus(1'b1, fpec_pkg::OFS_TABLE_WR_HIGH, {24'h0, exp_w[k][23:16]});
    end
    op(16'h4001, 0);
    @(posedge mclk_i);
    for (int k = 0; k < 8; k++) chk("row word", {8'h0, exp_w[k]}, {8'h0, i_arr.flash[k]});
    chk("stall", 32'h1, {31'h0, st});
    $display("test row program done");
    bus(1'b1, fpec_pkg::OFS_IRQ_CLEAR, 32'h3);
    bus(1'b1, fpec_pkg::OFS_IRQ_ENABLE, 32'h1);
    op(16'h4042, 2);
    rdchk("masked status", fpec_pkg::OFS_IRQ_STATUS, 32'h2);
    chk("masked irq", 32'h0, {31'h0, irq});
    chk("hresp", 32'h0, {31'h0, hresp});
    $display("test irq mask done");
    give_verdict();
  end
endmodule : test_flash_program_erase_control
`default_nettype wire
